/* File: rtl/prm_chan_route.sv */
// Purpose: Word index and ramp request of one channel
// Assumes: Pins already synchronised, bit 0 is profile pin zero
// Notes:   Purely combinational; the top registers the result

`default_nettype none

module prm_chan_route #(
  parameter logic [1:0] CH = 2'h0
) (
  input  wire prm_pkg::glob_cfg_s glob,
  input  wire prm_pkg::chan_cfg_s ccfg,
  input  wire logic [3:0]         pins,
  input  wire logic               sd_dir,
  output prm_pkg::chan_out_s      route
);

  wire       first   = prm_pkg::pair_first(glob.route) == {1'b1, CH};
  wire       second  = prm_pkg::pair_second(glob.route) == {1'b1, CH};
  wire       sel_one = glob.route[1:0] == CH;
  wire       mode_ok = prm_pkg::level_ok(glob.ramp_use, glob.level);
  wire       active  = (ccfg.mod_type != prm_pkg::MOD_OFF) &&
                       !ccfg.sweep_en; // RULE_18

  wire [3:0] idx_two   = {3'h0, pins[CH]};
  wire [3:0] idx_four  = first  ? {2'h0, pins[0], pins[1]} : // RULE_03
                         second ? {2'h0, pins[2], pins[3]} : // RULE_04
                         prm_pkg::WORD0_IDX;
  wire [3:0] idx_eight = sel_one ? {1'h0, pins[0], pins[1], pins[2]} :
                         prm_pkg::WORD0_IDX; // RULE_08
  wire [3:0] idx_sixt  = sel_one ? {pins[0], pins[1], pins[2], pins[3]} :
                         prm_pkg::WORD0_IDX; // RULE_05 RULE_09
  wire [3:0] idx_level = (glob.level == prm_pkg::LVL_TWO)   ? idx_two  :
                         (glob.level == prm_pkg::LVL_FOUR)  ? idx_four :
                         (glob.level == prm_pkg::LVL_EIGHT) ? idx_eight :
                         idx_sixt;
  wire [3:0] idx_rp    = first  ? {3'h0, pins[0]} : // RULE_11
                         second ? {3'h0, pins[1]} :
                         prm_pkg::WORD0_IDX;

  // Profile pin ramp sources
  wire       rp_en  = ((glob.ramp_use == prm_pkg::RAMP_P23) &&
                       (first || second)) || // RULE_10
                      ((glob.ramp_use == prm_pkg::RAMP_P3) && sel_one);
  wire       rp_dn  = (glob.ramp_use == prm_pkg::RAMP_P23 && first) ?
                      pins[2] : pins[3]; // RULE_11 RULE_13 RULE_16

  wire [3:0] idx_raw = (glob.ramp_use == prm_pkg::RAMP_P23) ? idx_rp :
                       (glob.ramp_use == prm_pkg::RAMP_P3) ? idx_eight :
                       idx_level; // RULE_12 RULE_13
  wire       serial  = glob.ramp_use == prm_pkg::RAMP_SERIAL; // RULE_14
  wire       use_pin = active && mode_ok;

  // Disabled channels stay on the dedicated word 0 register
  assign route.word_idx  = use_pin ? idx_raw :
                           prm_pkg::WORD0_IDX; // RULE_17 RULE_20
  assign route.mod_type  = active ? ccfg.mod_type :
                           prm_pkg::MOD_OFF; // RULE_18 RULE_19
  assign route.ramp_en   = serial ? 1'b1 : (use_pin && rp_en); // RULE_20
  assign route.ramp_down = serial ? sd_dir :
                           (use_pin && rp_en && rp_dn); // RULE_16

endmodule

`default_nettype wire

/* File: rtl/prm_pkg.sv */
// Purpose: Constants, field layouts and carriers of the profile pin router
// Assumes: Four channels, four profile pins, three serial data lines
// Notes:   Register map below is the router's own
//
// Contract
// (RULE_01) Four-level: level 01, type set, ramp/sweep off
// (RULE_02) Four-level: unused two channels get type 00
// (RULE_03) Four-level: pins 0-1 and 2-3 index words
// (RULE_04) Pin config code picks the channel pair
// (RULE_05) Lowest numbered pin is index MSB
// (RULE_06) Eight-level: level 10, nonzero type, ramp/sweep off
// (RULE_07) Eight/sixteen-level: three unused channels type 00
// (RULE_08) Eight-level: pins 0-2 index, pin 3 ignored
// (RULE_09) Sixteen-level: all four pins index word
// (RULE_10) Ramp usage 01: pins 2,3 ramp, two-level only
// (RULE_11) Two-level ramp: pins 0,1 modulate, 2,3 ramp
// (RULE_12) Ramp usage 10: pin 3 ramp, eight-level only
// (RULE_13) Eight-level ramp: pins 0-2 index, pin 3 ramps
// (RULE_14) Ramp usage 11: serial lines ramp; levels 2/4/16
// (RULE_15) Serial lines as ramp: single-line serial only
// (RULE_16) Ramp pin low ramps up, high down
// (RULE_17) Word 0 dedicated register, others profile registers
// (RULE_18) Type 00 off, 01 amp, 10 freq, 11 phase
// (RULE_19) Frequency 32, phase 14, amplitude 10 bits
// (RULE_20) Type 00 channel ignores pins, keeps word 0

`default_nettype none

package prm_pkg;

  localparam int NUM_CHAN = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_GLOBAL_FUNC = 8'h00;
  localparam logic [7:0] OFS_CHAN_FUNC0  = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h14;

  // Global function register fields
  localparam int GF_ROUTE_LSB = 12;
  localparam int GF_RAMP_LSB  = 10;
  localparam int GF_LEVEL_LSB = 8;

  // Channel function register fields
  localparam int CF_MOD_LSB   = 22;
  localparam int CF_SWEEP_BIT = 14;

  // Status register fields
  localparam int ST_IDX_LSB    = 0;
  localparam int ST_DN_LSB     = 16;
  localparam int ST_EN_LSB     = 20;
  localparam int ST_ERR_BIT    = 24;
  localparam int ST_SINGLE_BIT = 25;

  // Modulation levels
  localparam logic [1:0] LVL_TWO     = 2'h0;
  localparam logic [1:0] LVL_FOUR    = 2'h1;
  localparam logic [1:0] LVL_EIGHT   = 2'h2;
  localparam logic [1:0] LVL_SIXTEEN = 2'h3;

  // Ramp pin usage
  localparam logic [1:0] RAMP_OFF    = 2'h0;
  localparam logic [1:0] RAMP_P23    = 2'h1;
  localparam logic [1:0] RAMP_P3     = 2'h2;
  localparam logic [1:0] RAMP_SERIAL = 2'h3;

  // Modulation types
  localparam logic [1:0] MOD_OFF   = 2'h0;
  localparam logic [1:0] MOD_AMP   = 2'h1;
  localparam logic [1:0] MOD_FREQ  = 2'h2;
  localparam logic [1:0] MOD_PHASE = 2'h3;

  // Word widths and word sources
  localparam int         FREQ_W        = 32;
  localparam int         PHASE_W       = 14;
  localparam int         AMP_W         = 10;
  localparam logic [3:0] WORD0_IDX     = 4'h0;
  localparam logic [7:0] PROFILE_FIRST = 8'h0A;
  localparam logic [7:0] PROFILE_LAST  = 8'h18;

  // Reset values
  localparam logic [2:0] RST_ROUTE = 3'h0;
  localparam logic [1:0] RST_RAMP  = 2'h0;
  localparam logic [1:0] RST_LEVEL = 2'h0;
  localparam logic [1:0] RST_MOD   = 2'h0;
  localparam logic       RST_SWEEP = 1'h0;

  typedef struct packed {
    logic [2:0] route;
    logic [1:0] ramp_use;
    logic [1:0] level;
  } glob_cfg_s;

  typedef struct packed {
    logic [1:0] mod_type;
    logic       sweep_en;
  } chan_cfg_s;

  typedef struct packed {
    logic [3:0] word_idx;
    logic [1:0] mod_type;
    logic       ramp_en;
    logic       ramp_down;
  } chan_out_s;

  // Pair codes: {valid, channel} of first and second member
  function automatic logic [2:0] pair_first(input logic [2:0] code);
    case (code)
      3'h0, 3'h1, 3'h2: pair_first = 3'h4;
      3'h3, 3'h4:       pair_first = 3'h5;
      3'h5:             pair_first = 3'h6;
      default:          pair_first = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] pair_second(input logic [2:0] code);
    case (code)
      3'h0:       pair_second = 3'h5;
      3'h1, 3'h3: pair_second = 3'h6;
      3'h2, 3'h4, 3'h5: pair_second = 3'h7;
      default:    pair_second = 3'h0;
    endcase
  endfunction

  // Level allowed under a ramp pin usage
  function automatic logic level_ok(input logic [1:0] ramp,
                                    input logic [1:0] lvl);
    case (ramp)
      RAMP_P23:    level_ok = (lvl == LVL_TWO);
      RAMP_P3:     level_ok = (lvl == LVL_EIGHT);
      RAMP_SERIAL: level_ok = (lvl != LVL_EIGHT);
      default:     level_ok = 1'b1;
    endcase
  endfunction

endpackage

`default_nettype wire

/* File: rtl/prm_router.sv */
// Purpose: Routes profile pins and serial lines to four channels
// Assumes: Pins and serial lines are asynchronous to clk_sys
// Notes:   Outputs lag the pins by three clock edges

`default_nettype none

module prm_router (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata_q,
  input  wire logic                   profile_pin_zero,
  input  wire logic                   profile_pin_one,
  input  wire logic                   profile_pin_two,
  input  wire logic                   profile_pin_three,
  input  wire logic                   serial_line_one,
  input  wire logic                   serial_line_two,
  input  wire logic                   serial_line_three,
  output prm_pkg::chan_out_s [3:0]    chan_q,
  output logic                        serial_single_line_q,
  output logic                        route_cfg_err_q
);

  // Input synchronisers
  logic [3:0] pin_meta_q;
  logic [3:0] pin_s_q;
  logic [2:0] sdio_meta_q;
  logic [2:0] sdio_s_q;

  wire  [3:0] pin_raw  = {profile_pin_three, profile_pin_two,
                          profile_pin_one, profile_pin_zero};
  wire  [2:0] sdio_raw = {serial_line_three, serial_line_two,
                          serial_line_one};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q  <= 4'h0;
      pin_s_q     <= 4'h0;
      sdio_meta_q <= 3'h0;
      sdio_s_q    <= 3'h0;
    end else begin
      pin_meta_q  <= pin_raw;
      pin_s_q     <= pin_meta_q;
      sdio_meta_q <= sdio_raw;
      sdio_s_q    <= sdio_meta_q;
    end
  end

  // Configuration registers
  prm_pkg::glob_cfg_s       glob_q;
  prm_pkg::chan_cfg_s [3:0] ccfg_q;

  wire [7:0] ch_off  = reg_addr - prm_pkg::OFS_CHAN_FUNC0;
  wire [1:0] ch_sel  = ch_off[3:2];
  wire       hit_glb = reg_addr == prm_pkg::OFS_GLOBAL_FUNC;
  wire       hit_chn = (ch_off[7:4] == 4'h0) && (ch_off[1:0] == 2'h0);
  wire       hit_st  = reg_addr == prm_pkg::OFS_STATUS;

  wire prm_pkg::glob_cfg_s glob_wr = '{
    route:    reg_wdata[prm_pkg::GF_ROUTE_LSB +: 3],
    ramp_use: reg_wdata[prm_pkg::GF_RAMP_LSB +: 2],
    level:    reg_wdata[prm_pkg::GF_LEVEL_LSB +: 2]
  };
  wire prm_pkg::chan_cfg_s ccfg_wr = '{
    mod_type: reg_wdata[prm_pkg::CF_MOD_LSB +: 2],
    sweep_en: reg_wdata[prm_pkg::CF_SWEEP_BIT]
  };

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      glob_q <= '{prm_pkg::RST_ROUTE, prm_pkg::RST_RAMP,
                  prm_pkg::RST_LEVEL};
    end else if (reg_wr && hit_glb) begin
      glob_q <= glob_wr;
    end
  end

  generate
    for (genvar c = 0; c < prm_pkg::NUM_CHAN; c++) begin : g_ccfg
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          ccfg_q[c] <= '{prm_pkg::RST_MOD, prm_pkg::RST_SWEEP};
        end else if (reg_wr && hit_chn && (ch_sel == 2'(c))) begin
          ccfg_q[c] <= ccfg_wr;
        end
      end
    end
  endgenerate

  // Serial line ramp direction, latched per addressed channel
  logic [3:0] sd_dir_q;
  wire        serial_ramp = glob_q.ramp_use == prm_pkg::RAMP_SERIAL;
  wire  [1:0] sd_chan     = {sdio_s_q[0], sdio_s_q[1]};

  generate
    for (genvar c = 0; c < prm_pkg::NUM_CHAN; c++) begin : g_sdir
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          sd_dir_q[c] <= 1'b0;
        end else if (serial_ramp && (sd_chan == 2'(c))) begin
          sd_dir_q[c] <= sdio_s_q[2]; // RULE_14 RULE_16
        end
      end
    end
  endgenerate

  // Per channel routing
  prm_pkg::chan_out_s [3:0] chan_d;

  generate
    for (genvar c = 0; c < prm_pkg::NUM_CHAN; c++) begin : g_chan
      prm_chan_route #(
        .CH (2'(c))
      ) u_route (
        .glob   (glob_q),
        .ccfg   (ccfg_q[c]),
        .pins   (pin_s_q),
        .sd_dir (sd_dir_q[c]),
        .route  (chan_d[c])
      );
    end
  endgenerate

  wire cfg_err_d = !prm_pkg::level_ok(glob_q.ramp_use, glob_q.level);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chan_q               <= '0;
      serial_single_line_q <= 1'b0;
      route_cfg_err_q      <= 1'b0;
    end else begin
      chan_q               <= chan_d;
      serial_single_line_q <= serial_ramp; // RULE_15
      route_cfg_err_q      <= cfg_err_d;
    end
  end

  // Read path
  logic [31:0] st_word;
  logic [31:0] glb_word;
  logic [31:0] chn_word;

  always_comb begin
    st_word  = 32'h0;
    glb_word = 32'h0;
    chn_word = 32'h0;
    for (int c = 0; c < prm_pkg::NUM_CHAN; c++) begin
      st_word[prm_pkg::ST_IDX_LSB + 4*c +: 4] = chan_q[c].word_idx;
      st_word[prm_pkg::ST_DN_LSB + c]         = chan_q[c].ramp_down;
      st_word[prm_pkg::ST_EN_LSB + c]         = chan_q[c].ramp_en;
    end
    st_word[prm_pkg::ST_ERR_BIT]           = route_cfg_err_q;
    st_word[prm_pkg::ST_SINGLE_BIT]        = serial_single_line_q;
    glb_word[prm_pkg::GF_ROUTE_LSB +: 3]   = glob_q.route;
    glb_word[prm_pkg::GF_RAMP_LSB +: 2]    = glob_q.ramp_use;
    glb_word[prm_pkg::GF_LEVEL_LSB +: 2]   = glob_q.level;
    chn_word[prm_pkg::CF_MOD_LSB +: 2]     = ccfg_q[ch_sel].mod_type;
    chn_word[prm_pkg::CF_SWEEP_BIT]        = ccfg_q[ch_sel].sweep_en;
  end

  wire [31:0] rd_mux = hit_glb ? glb_word :
                       hit_chn ? chn_word :
                       hit_st  ? st_word  : 32'h0;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 32'h0;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  wire plain_mode = glob_q.ramp_use == prm_pkg::RAMP_OFF;

  sequence s_sd_addr_ch2_down;
    serial_ramp && (sdio_s_q == 3'h5);
  endsequence

  chk_four_level_first: assert property ( // RULE_03
    (plain_mode && glob_q.level == prm_pkg::LVL_FOUR &&
     glob_q.route == 3'h2 && ccfg_q[0] == 3'h4)
    |=> chan_q[0].word_idx == {2'h0, $past(pin_s_q[0]), $past(pin_s_q[1])})
    else $error("four-level index of first channel wrong");

  chk_four_level_pair: assert property ( // RULE_04
    (plain_mode && glob_q.level == prm_pkg::LVL_FOUR &&
     glob_q.route == 3'h2 && ccfg_q[3] == 3'h6)
    |=> chan_q[3].word_idx == {2'h0, $past(pin_s_q[2]), $past(pin_s_q[3])})
    else $error("four-level index of second channel wrong");

  chk_eight_level_idx: assert property ( // RULE_08
    (plain_mode && glob_q.level == prm_pkg::LVL_EIGHT &&
     glob_q.route[1:0] == 2'h2 && ccfg_q[2] == 3'h2)
    |=> chan_q[2].word_idx == {1'h0, $past(pin_s_q[0]),
                               $past(pin_s_q[1]), $past(pin_s_q[2])})
    else $error("eight-level index wrong");

  chk_sixteen_msb: assert property ( // RULE_05
    (plain_mode && glob_q.level == prm_pkg::LVL_SIXTEEN &&
     glob_q.route[1:0] == 2'h3 && pin_s_q == 4'h7 &&
     ccfg_q[3].mod_type != prm_pkg::MOD_OFF && !ccfg_q[3].sweep_en)
    |=> chan_q[3].word_idx == 4'hE)
    else $error("sixteen-level bit order wrong");

  chk_ramp_pair_pins: assert property ( // RULE_11
    (glob_q.ramp_use == prm_pkg::RAMP_P23 &&
     glob_q.level == prm_pkg::LVL_TWO && glob_q.route == 3'h0 &&
     ccfg_q[1] == 3'h4)
    |=> chan_q[1].ramp_en && chan_q[1].ramp_down == $past(pin_s_q[3]) &&
        chan_q[1].word_idx == {3'h0, $past(pin_s_q[1])})
    else $error("two-level ramp pin routing wrong");

  chk_eight_ramp_pin: assert property ( // RULE_13
    (glob_q.ramp_use == prm_pkg::RAMP_P3 &&
     glob_q.level == prm_pkg::LVL_EIGHT && glob_q.route[1:0] == 2'h2 &&
     ccfg_q[2] == 3'h6)
    |=> chan_q[2].ramp_en && chan_q[2].ramp_down == $past(pin_s_q[3]))
    else $error("eight-level ramp pin routing wrong");

  chk_sdio_ramp_dir: assert property ( // RULE_14
    s_sd_addr_ch2_down |-> ##2 (chan_q[2].ramp_en && chan_q[2].ramp_down))
    else $error("serial line ramp request lost");

  chk_single_line: assert property ( // RULE_15
    $changed(glob_q.ramp_use)
    |=> serial_single_line_q ==
        ($past(glob_q.ramp_use) == prm_pkg::RAMP_SERIAL))
    else $error("single-line flag does not follow ramp usage");

  chk_disabled_word0: assert property ( // RULE_20
    (ccfg_q[0].mod_type == prm_pkg::MOD_OFF && !serial_ramp)
    |=> chan_q[0].word_idx == prm_pkg::WORD0_IDX && !chan_q[0].ramp_en)
    else $error("disabled channel follows pins");

  chk_bad_level_flag: assert property ( // RULE_10
    (glob_q.ramp_use == prm_pkg::RAMP_P23 &&
     glob_q.level != prm_pkg::LVL_TWO)
    |=> route_cfg_err_q && chan_q[0].word_idx == prm_pkg::WORD0_IDX)
    else $error("illegal level under ramp pins not refused");

endmodule

`default_nettype wire

/* File: testbench/prm_pin_ctl.sv */
// Purpose: Model of the external controller on pins and serial lines
// Assumes: Bench calls the tasks from its own thread
// Notes:   Lines change only just after a rising edge, always driven

`default_nettype none

module prm_pin_ctl (
  input  wire logic clk_sys,
  output var  logic pin_zero,
  output var  logic pin_one,
  output var  logic pin_two,
  output var  logic pin_three,
  output var  logic line_one,
  output var  logic line_two,
  output var  logic line_three
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {pin_three, pin_two, pin_one, pin_zero} = 4'h0;
    {line_one, line_two, line_three}        = 3'h0;
  end

  // Profile pin pattern, bit 0 is pin zero
  task automatic put_pins(input logic [3:0] v);
    @(posedge clk_sys);
    {pin_three, pin_two, pin_one, pin_zero} <= v;
  endtask

  // Ramp code as {one, two, three}; single-line use only
  task automatic put_serial(input logic [2:0] v);
    @(posedge clk_sys);
    {line_one, line_two, line_three} <= v;
  endtask

endmodule

`default_nettype wire

/* File: testbench/prm_router_bench.sv */
// Purpose: Self-checking bench of the profile pin router
// Assumes: Pin controller model drives pins and serial lines
// Notes:   Each scenario after t_reset configures, drives, settles and compares

`default_nettype none

module prm_router_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     clk_sys;
  logic                     rstn;
  logic [7:0]               reg_addr;
  logic [31:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [31:0]              reg_rdata_q;
  logic                     pin_zero;
  logic                     pin_one;
  logic                     pin_two;
  logic                     pin_three;
  logic                     line_one;
  logic                     line_two;
  logic                     line_three;
  prm_pkg::chan_out_s [3:0] chan_q;
  logic                     single_q;
  logic                     err_q;
  logic [31:0]              rv;
  int                       failures;
  int                       tests_run;
  int                       cycles;
  int                       fa[6] = '{0, 0, 0, 1, 1, 2};
  int                       sa[6] = '{1, 2, 3, 2, 3, 3};

  prm_pin_ctl u_ctl (
    .clk_sys(clk_sys), .pin_zero(pin_zero), .pin_one(pin_one),
    .pin_two(pin_two), .pin_three(pin_three), .line_one(line_one),
    .line_two(line_two), .line_three(line_three)
  );

  prm_router u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .profile_pin_zero(pin_zero),
    .profile_pin_one(pin_one), .profile_pin_two(pin_two),
    .profile_pin_three(pin_three), .serial_line_one(line_one),
    .serial_line_two(line_two), .serial_line_three(line_three),
    .chan_q(chan_q), .serial_single_line_q(single_q),
    .route_cfg_err_q(err_q)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask

  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic gcfg(input logic [2:0] rt, input logic [1:0] rp,
                      input logic [1:0] lv);
    wr(prm_pkg::OFS_GLOBAL_FUNC, (32'(rt) << prm_pkg::GF_ROUTE_LSB)
       | (32'(rp) << prm_pkg::GF_RAMP_LSB)
       | (32'(lv) << prm_pkg::GF_LEVEL_LSB));
  endtask

  // Two bits of mod type per channel, channel 0 lowest
  task automatic mods(input logic [7:0] m, input logic sw);
    for (int c = 0; c < 4; c++)
      wr(prm_pkg::OFS_CHAN_FUNC0 + 8'(4 * c),
         (32'(m[2*c +: 2]) << prm_pkg::CF_MOD_LSB)
         | (32'(sw) << prm_pkg::CF_SWEEP_BIT));
  endtask

  task automatic chk_ch(input int c, input logic [3:0] idx,
                        input logic [1:0] mt, input logic en,
                        input logic dn);
    check($sformatf("chan%0d", c), 32'(chan_q[c]), 32'({idx, mt, en, dn}));
  endtask

  task automatic t_reset();
    check("chan after reset", chan_q, 32'h0);
    for (int c = 0; c < 6; c++) begin
      rd(8'(4 * c), rv);
      check("reg after reset", rv, 32'h0);
    end
    rd(8'hFC, rv);
    check("unmapped read", rv, 32'h0);
    gcfg(3'h7, 2'h3, 2'h3);
    rd(prm_pkg::OFS_GLOBAL_FUNC, rv);
    check("global readback", rv, 32'h00007F00);
    @(posedge clk_sys);
    #1 check("read data one cycle", reg_rdata_q, 32'h0);
  endtask

  task automatic t_four();
    u_ctl.put_pins(4'hB);
    for (int k = 0; k < 6; k++) begin
      mods((8'(prm_pkg::MOD_FREQ) << (2 * fa[k]))
           | (8'(prm_pkg::MOD_PHASE) << (2 * sa[k])), 1'b0);
      gcfg(3'(k), prm_pkg::RAMP_OFF, prm_pkg::LVL_FOUR);
      settle();
      for (int c = 0; c < 4; c++)
        if (c == fa[k])
          chk_ch(c, 4'h3, prm_pkg::MOD_FREQ, 0, 0);
        else if (c == sa[k])
          chk_ch(c, 4'h1, prm_pkg::MOD_PHASE, 0, 0);
        else chk_ch(c, 4'h0, prm_pkg::MOD_OFF, 0, 0);
    end
  endtask

  task automatic t_eight();
    for (int c = 0; c < 4; c++) begin
      mods(8'(prm_pkg::MOD_AMP) << (2 * c), 1'b0);
      gcfg({1'b1, 2'(c)}, prm_pkg::RAMP_OFF, prm_pkg::LVL_EIGHT);
      for (int p = 0; p < 2; p++) begin
        u_ctl.put_pins({1'(p), 3'h7});
        settle();
        chk_ch(c, 4'h7, prm_pkg::MOD_AMP, 0, 0);
        chk_ch((c + 1) % 4, 4'h0, prm_pkg::MOD_OFF, 0, 0);
      end
    end
  endtask

  task automatic t_sixteen();
    mods(8'(prm_pkg::MOD_PHASE) << 6, 1'b0);
    gcfg(3'h3, prm_pkg::RAMP_OFF, prm_pkg::LVL_SIXTEEN);
    u_ctl.put_pins(4'h7);
    settle();
    chk_ch(3, 4'hE, prm_pkg::MOD_PHASE, 0, 0);
    rd(prm_pkg::OFS_STATUS, rv);
    check("status", rv, 32'h0000E000);
    mods(8'(prm_pkg::MOD_PHASE) << 6, 1'b1);
    settle();
    chk_ch(3, 4'h0, prm_pkg::MOD_OFF, 0, 0);
  endtask

  task automatic t_types();
    mods(8'hE4, 1'b0);
    gcfg(3'h0, prm_pkg::RAMP_OFF, prm_pkg::LVL_TWO);
    u_ctl.put_pins(4'hF);
    settle();
    for (int c = 0; c < 4; c++)
      chk_ch(c, (c == 0) ? 4'h0 : 4'h1, 2'(c), 0, 0);
  endtask

  task automatic t_ramp_pins();
    u_ctl.put_pins(4'h9);
    for (int k = 0; k < 6; k++) begin
      mods((8'(prm_pkg::MOD_AMP) << (2 * fa[k]))
           | (8'(prm_pkg::MOD_FREQ) << (2 * sa[k])), 1'b0);
      gcfg(3'(k), prm_pkg::RAMP_P23, prm_pkg::LVL_TWO);
      settle();
      chk_ch(fa[k], 4'h1, prm_pkg::MOD_AMP, 1, 0);
      chk_ch(sa[k], 4'h0, prm_pkg::MOD_FREQ, 1, 1);
    end
    mods(8'(prm_pkg::MOD_PHASE) << 4, 1'b0);
    gcfg(3'h6, prm_pkg::RAMP_P3, prm_pkg::LVL_EIGHT);
    u_ctl.put_pins(4'hD);
    settle();
    chk_ch(2, 4'h5, prm_pkg::MOD_PHASE, 1, 1);
    u_ctl.put_pins(4'h5);
    settle();
    chk_ch(2, 4'h5, prm_pkg::MOD_PHASE, 1, 0);
  endtask

  task automatic t_serial();
    mods(8'h00, 1'b0);
    u_ctl.put_pins(4'h0);
    gcfg(3'h0, prm_pkg::RAMP_SERIAL, prm_pkg::LVL_TWO);
    settle();
    check("single line", single_q, 32'h1);
    for (int k = 0; k < 8; k++) begin
      u_ctl.put_serial(3'(k));
      settle();
      chk_ch(k / 2, 4'h0, prm_pkg::MOD_OFF, 1, k % 2);
    end
    gcfg(3'h0, prm_pkg::RAMP_SERIAL, prm_pkg::LVL_EIGHT);
    settle();
    check("serial level err", err_q, 32'h1);
    gcfg(3'h0, prm_pkg::RAMP_P23, prm_pkg::LVL_FOUR);
    settle();
    check("p23 level err", err_q, 32'h1);
    check("single line off", single_q, 32'h0);
    gcfg(3'h0, prm_pkg::RAMP_P3, prm_pkg::LVL_TWO);
    settle();
    check("p3 level err", err_q, 32'h1);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    rstn      = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_four();
    t_eight();
    t_sixteen();
    t_types();
    t_ramp_pins();
    t_serial();
    end_of_test();
  end

endmodule

`default_nettype wire
